// *** ifs_consts.vh ***
// Register map, field positions and timing counts of the inrush fault supervisor.
`ifndef IFS_CONSTS_VH
`define IFS_CONSTS_VH

`define IFS_ADDR_CONTROL 8'h00
`define IFS_ADDR_LOG 8'h04
`define IFS_ADDR_HEALTH 8'h06
`define IFS_ADDR_STATUS 8'h1e

`define IFS_CTL_OV_RETRY 0
`define IFS_CTL_UV_RETRY 1
`define IFS_CTL_OC_RETRY 2
`define IFS_CTL_SWITCH_CMD 3
`define IFS_CTL_POLARITY 5
`define IFS_CTL_DEBOUNCE 6
`define IFS_CTL_RETAIN_LOG 7

`define IFS_BIT_OV 0
`define IFS_BIT_UV 1
`define IFS_BIT_OC 2
`define IFS_BIT_CARD 4
`define IFS_BIT_LEAK 5
`define IFS_BIT_FETBAD 6

`define IFS_RESET_BYTE 8'h00
`define IFS_LOG_CARD_ONLY 8'h10

`define IFS_CLK_MHZ 40
`define IFS_FILTER_NS 15000
`define IFS_QUAL_MS 50
`define IFS_STEP_MS 1
// Counts are 15us, 50ms and 1ms at the 40 MHz clock, sized to the counter width.
`define IFS_FILTER_CYC 22'h000258
`define IFS_QUAL_CYC 22'h1e8480
`define IFS_STEP_CYC 22'h009c40

`define IFS_CB_TOP 12'h500
`define IFS_CB_LOW 12'h096
`define IFS_CB_UP 12'h004
`define IFS_CB_DOWN 12'h001
`define IFS_COOL_CYCLES 9'h100

`endif

// *** ifs_inrush_fault_supervisor.v ***
// Fault supervision and pass switch enable for a live-insertion power controller.
`include "ifs_consts.vh"

module ifs_inrush_fault_supervisor #(
  parameter CW = 22,
  parameter [CW-1:0] QUAL_CYC = `IFS_QUAL_CYC,
  parameter [CW-1:0] STEP_CYC = `IFS_STEP_CYC,
  parameter [CW-1:0] FILTER_CYC = `IFS_FILTER_CYC,
  parameter [11:0] CB_TOP = `IFS_CB_TOP,
  parameter [11:0] CB_LOW = `IFS_CB_LOW,
  parameter [11:0] CB_UP = `IFS_CB_UP,
  parameter [11:0] CB_DOWN = `IFS_CB_DOWN
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Analog comparator and pin inputs
  input wire highInputSense,
  input wire lowInputSense,
  input wire cardSense,
  input wire currentLimitActive,
  input wire drainSourceHigh,
  input wire gateEnhanced,
  input wire leakMeasured,
  input wire supplyLockout,
  // Nonvolatile defaults loaded on leaving lockout
  input wire [7:0] nvControl,
  input wire [7:0] nvHealthDelay,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [7:0] regRdData,
  // Pass switch drive
  output reg switchDriveOn
);

  localparam ST_RUN = 3'b001;
  localparam ST_FALL = 3'b010;
  localparam ST_RISE = 3'b100;
  localparam [8:0] COOL_LAST = `IFS_COOL_CYCLES;

  reg [7:0] switchControl;
  reg [7:0] latchedErrorRecord;
  reg [7:0] switchHealthDelay;
  reg [2:0] cbState;
  reg [11:0] cbCount;
  reg [8:0] coolCycles;
  reg ocPresent;
  reg fetBadPresent;
  reg [CW-1:0] stepCount;
  reg [7:0] msCount;
  reg cardIgnore;
  reg latchPending;
  reg cardPrev;
  reg lockPrev;
  wire ovQual;
  wire uvQual;
  wire cardSync;
  wire cardDeb;
  wire limitSync;
  wire dsSync;
  wire gateSync;
  wire leakSync;
  wire lockSync;
  wire cardActive;
  wire cardActiveDeb;
  wire cardToggle;
  wire cardRise;
  wire cardFall;
  wire lockExit;
  wire leakPresent;
  wire healthBad;
  wire ocTrip;
  wire fetBadTrip;
  wire coolDone;
  wire [7:0] liveConditionFlags;
  wire [7:0] logSet;
  wire holdOff;
  wire onRequest;
  reg [7:0] next_log;

  // Over/undervoltage: 15us to declare, 50ms to recover.
  ifs_qual_filter #(.CW(CW), .ASSERT_CYC(FILTER_CYC), .RELEASE_CYC(QUAL_CYC)) uOv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(highInputSense),
    .syncLevel(),
    .qualified(ovQual)
  );
  ifs_qual_filter #(.CW(CW), .ASSERT_CYC(FILTER_CYC), .RELEASE_CYC(QUAL_CYC)) uUv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(~lowInputSense),
    .syncLevel(),
    .qualified(uvQual)
  );
  // Card sense: synced level for edges, both-way debounced copy for delayed start.
  ifs_qual_filter #(.CW(CW), .ASSERT_CYC(QUAL_CYC), .RELEASE_CYC(QUAL_CYC)) uCard (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(cardSense),
    .syncLevel(cardSync),
    .qualified(cardDeb)
  );
  // Plain synchronisers for the remaining comparators.
  ifs_qual_filter #(.CW(CW)) uLimit (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(currentLimitActive),
    .syncLevel(limitSync),
    .qualified()
  );
  ifs_qual_filter #(.CW(CW)) uDs (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(drainSourceHigh),
    .syncLevel(dsSync),
    .qualified()
  );
  ifs_qual_filter #(.CW(CW)) uGate (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(gateEnhanced),
    .syncLevel(gateSync),
    .qualified()
  );
  ifs_qual_filter #(.CW(CW)) uLeak (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(leakMeasured),
    .syncLevel(leakSync),
    .qualified()
  );
  ifs_qual_filter #(.CW(CW)) uLock (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(supplyLockout),
    .syncLevel(lockSync),
    .qualified()
  );

  assign cardActive = switchControl[`IFS_CTL_POLARITY] ? cardSync : ~cardSync;
  assign cardActiveDeb = switchControl[`IFS_CTL_POLARITY] ? cardDeb : ~cardDeb;
  assign cardToggle = cardSync ^ cardPrev;
  assign cardRise = cardToggle & (cardActive);
  assign cardFall = cardToggle & ~cardActive;
  assign lockExit = lockPrev & ~lockSync;

  assign leakPresent = leakSync & ~switchDriveOn;
  // Drain-source or gate enhancement shortfall; gate check only counts while on.
  assign healthBad = dsSync | (~gateSync & switchDriveOn);

  assign ocTrip = (cbState == ST_RUN) & limitSync & switchDriveOn &
    (cbCount + CB_UP >= CB_TOP);
  assign fetBadTrip = (cbState == ST_RUN) & switchDriveOn & healthBad &
    (switchHealthDelay != 8'h00) & (stepCount == STEP_CYC - 1'b1) &
    (msCount + 1'b1 == switchHealthDelay);
  assign coolDone = (cbState == ST_FALL) & (cbCount <= CB_LOW) &
    (coolCycles == COOL_LAST - 1'b1);

  assign liveConditionFlags = {1'b0, fetBadPresent, leakPresent, 2'b00, ocPresent,
    uvQual, ovQual};
  assign logSet = {1'b0, fetBadTrip, leakPresent, 1'b0, 1'b0, ocTrip, uvQual, ovQual} |
    liveConditionFlags;

  // Retry on: present holds off; retry off: the logged bit also holds off.
  assign holdOff = ovQual | uvQual | ocPresent | fetBadPresent | ocTrip | fetBadTrip |
    (~switchControl[`IFS_CTL_OV_RETRY] & latchedErrorRecord[`IFS_BIT_OV]) |
    (~switchControl[`IFS_CTL_UV_RETRY] & latchedErrorRecord[`IFS_BIT_UV]) |
    (~switchControl[`IFS_CTL_OC_RETRY] & latchedErrorRecord[`IFS_BIT_OC]) |
    (~switchControl[`IFS_CTL_OC_RETRY] & latchedErrorRecord[`IFS_BIT_FETBAD]);

  // Card gating is dropped when the loaded command said to ignore the pin.
  assign onRequest = switchControl[`IFS_CTL_SWITCH_CMD] & ~latchPending & (cardIgnore |
    (switchControl[`IFS_CTL_DEBOUNCE] ? cardActiveDeb : cardActive));

  always @*
  begin
    next_log = latchedErrorRecord;
    if (regWrEn && regAddr == `IFS_ADDR_LOG)
      next_log = latchedErrorRecord & regWrData;
    if (cardToggle && !switchControl[`IFS_CTL_RETAIN_LOG])
      next_log = `IFS_LOG_CARD_ONLY;
    else if (cardToggle)
      next_log = next_log | `IFS_LOG_CARD_ONLY;
    // Setting after clearing lets a fresh or still-present fault win.
    next_log = next_log | logSet;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      switchControl <= `IFS_RESET_BYTE;
      latchedErrorRecord <= `IFS_RESET_BYTE;
      switchHealthDelay <= `IFS_RESET_BYTE;
      regRdData <= `IFS_RESET_BYTE;
      cardIgnore <= 1'b1;
      latchPending <= 1'b0;
      cardPrev <= 1'b0;
      lockPrev <= 1'b1;
      switchDriveOn <= 1'b0;
    end
    else
    begin
      cardPrev <= cardSync;
      lockPrev <= lockSync;
      if (lockSync)
      begin
        // Everything stays off and the log is cleared during lockout.
        latchedErrorRecord <= `IFS_RESET_BYTE;
        switchDriveOn <= 1'b0;
      end
      else if (lockExit)
      begin
        switchControl <= nvControl;
        switchHealthDelay <= nvHealthDelay;
        cardIgnore <= ~nvControl[`IFS_CTL_SWITCH_CMD];
        latchPending <= nvControl[`IFS_CTL_SWITCH_CMD];
        switchDriveOn <= 1'b0;
      end
      else
      begin
        latchedErrorRecord <= next_log;
        if (regWrEn && regAddr == `IFS_ADDR_CONTROL)
        begin
          switchControl <= regWrData;
          cardIgnore <= 1'b0;
        end
        if (regWrEn && regAddr == `IFS_ADDR_HEALTH)
          switchHealthDelay <= regWrData;
        // Card edges outrank a same-cycle host write of the command bit.
        if (latchPending && cardDeb == cardSync)
        begin
          switchControl[`IFS_CTL_SWITCH_CMD] <= cardActiveDeb;
          latchPending <= 1'b0;
        end
        else if (!cardIgnore && !latchPending && cardRise)
          switchControl[`IFS_CTL_SWITCH_CMD] <= 1'b1;
        else if (!cardIgnore && !latchPending && cardFall)
          switchControl[`IFS_CTL_SWITCH_CMD] <= 1'b0;
        switchDriveOn <= onRequest & ~holdOff;
      end
      if (regRdEn)
      begin
        case (regAddr)
          `IFS_ADDR_CONTROL: regRdData <= switchControl;
          `IFS_ADDR_LOG: regRdData <= latchedErrorRecord;
          `IFS_ADDR_HEALTH: regRdData <= switchHealthDelay;
          `IFS_ADDR_STATUS: regRdData <= liveConditionFlags;
          default: regRdData <= `IFS_RESET_BYTE;
        endcase
      end
    end
  end

  // Breaker delay counter standing in for the timing capacitor ramp.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cbState <= ST_RUN;
      cbCount <= 12'h000;
      coolCycles <= 9'h000;
      ocPresent <= 1'b0;
      fetBadPresent <= 1'b0;
    end
    else
    begin
      case (cbState)
        ST_RUN:
        begin
          if (ocTrip || fetBadTrip)
          begin
            cbState <= ST_FALL;
            ocPresent <= ocTrip;
            fetBadPresent <= fetBadTrip;
            coolCycles <= 9'h000;
            cbCount <= ocTrip ? CB_TOP : cbCount;
          end
          else if (limitSync && switchDriveOn)
            cbCount <= cbCount + CB_UP;
          else if (cbCount >= CB_DOWN)
            cbCount <= cbCount - CB_DOWN;
          else
            cbCount <= 12'h000;
        end
        ST_FALL:
        begin
          if (cbCount <= CB_LOW)
          begin
            if (coolDone)
            begin
              // Present bits drop here; retry or a cleared log then allows turn-on.
              cbState <= ST_RUN;
              ocPresent <= 1'b0;
              fetBadPresent <= 1'b0;
              cbCount <= 12'h000;
            end
            else
            begin
              cbState <= ST_RISE;
              coolCycles <= coolCycles + 1'b1;
            end
          end
          else
            cbCount <= cbCount - CB_DOWN;
        end
        ST_RISE:
        begin
          if (cbCount + CB_UP >= CB_TOP)
          begin
            cbCount <= CB_TOP;
            cbState <= ST_FALL;
          end
          else
            cbCount <= cbCount + CB_UP;
        end
        default:
          cbState <= ST_RUN;
      endcase
    end
  end

  // Millisecond health timer; any healthy cycle or off command restarts it.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stepCount <= {CW{1'b0}};
      msCount <= 8'h00;
    end
    else if (!(switchDriveOn && healthBad) || fetBadTrip ||
      switchHealthDelay == 8'h00)
    begin
      stepCount <= {CW{1'b0}};
      msCount <= 8'h00;
    end
    else if (stepCount == STEP_CYC - 1'b1)
    begin
      stepCount <= {CW{1'b0}};
      msCount <= msCount + 1'b1;
    end
    else
      stepCount <= stepCount + 1'b1;
  end

endmodule

// *** ifs_pass_switch_model.sv ***
// Behavioural pass transistor and sense comparators facing the supervisor.
module ifs_pass_switch_model (
  // Clock
  input wire ref_clk,
  // Drive and injected faults
  input wire switchDriveOn,
  input wire shortLoad,
  input wire gateLeak,
  input wire leakPath,
  // Comparator levels
  output logic currentLimitActive,
  output logic drainSourceHigh,
  output logic gateEnhanced,
  output logic leakMeasured
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ramp = 3'h0;
  // The gate takes a few cycles to charge, so every turn-on shows a brief health fault.
  always @(posedge ref_clk)
    ramp <= !switchDriveOn ? 3'h0 : (ramp[2] ? ramp : ramp + 3'h1);
  assign gateEnhanced = ramp[2] && !gateLeak;
  assign drainSourceHigh = !gateEnhanced;
  assign currentLimitActive = switchDriveOn && shortLoad;
  assign leakMeasured = !switchDriveOn && leakPath;
endmodule

// *** ifs_qual_filter.v ***
// Three-flop synchroniser with separate assert and release qualification times.
module ifs_qual_filter #(
  parameter CW = 22,
  parameter [CW-1:0] ASSERT_CYC = 1,
  parameter [CW-1:0] RELEASE_CYC = 1
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Asynchronous level in
  input wire rawIn,
  // Synchronised and qualified levels
  output reg syncLevel,
  output reg qualified
);

  reg s1;
  reg s2;
  reg s3;
  reg [CW-1:0] cnt;
  wire [CW-1:0] lastCount;

  assign lastCount = qualified ? (RELEASE_CYC - 1'b1) : (ASSERT_CYC - 1'b1);

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      syncLevel <= 1'b0;
      qualified <= 1'b0;
      cnt <= {CW{1'b0}};
    end
    else
    begin
      s1 <= rawIn;
      s2 <= s1;
      s3 <= s2;
      // A change only counts once the second and third stages agree.
      if (s2 == s3)
        syncLevel <= s3;
      if (syncLevel == qualified)
        cnt <= {CW{1'b0}};
      else if (cnt >= lastCount)
      begin
        qualified <= syncLevel;
        cnt <= {CW{1'b0}};
      end
      else
        cnt <= cnt + 1'b1;
    end
  end

endmodule

// *** ifs_sup_props.sv ***
// Property checker on the switch drive of the inrush fault supervisor.
module ifs_sup_props #(
  parameter CW = 22,
  parameter [CW-1:0] QUAL_CYC = 1,
  parameter [CW-1:0] FILTER_CYC = 1,
  parameter [11:0] CB_TOP = 1,
  parameter [11:0] CB_LOW = 0,
  parameter [11:0] CB_UP = 1,
  parameter [11:0] CB_DOWN = 1
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Watched inputs and drive
  input wire highInputSense,
  input wire lowInputSense,
  input wire currentLimitActive,
  input wire supplyLockout,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire switchDriveOn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slack for the synchroniser, its agree check and the output register.
  localparam int LAG = 8;
  localparam int OC_MAX = CB_TOP / CB_UP + LAG;
  localparam int COOL_MIN = 256 * ((CB_TOP - CB_LOW) / CB_DOWN);
  logic [31:0] hiCnt = 32'h0, hiLow = 32'h0, loCnt = 32'h0, loHigh = 32'h0;
  logic [31:0] ocCnt = 32'h0, offCnt = 32'h0;
  logic ovSeen = 1'b0, uvSeen = 1'b0, ocTrip = 1'b0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Input counters run through reset because they track pins, not design state.
  always @(posedge ref_clk)
  begin
    hiCnt <= highInputSense ? hiCnt + 32'h1 : 32'h0;
    hiLow <= highInputSense ? 32'h0 : hiLow + 32'h1;
    loCnt <= lowInputSense ? 32'h0 : loCnt + 32'h1;
    loHigh <= lowInputSense ? loHigh + 32'h1 : 32'h0;
    ocCnt <= (currentLimitActive && switchDriveOn) ? ocCnt + 32'h1 : 32'h0;
    offCnt <= switchDriveOn ? 32'h0 : offCnt + 32'h1;
    ovSeen <= ovSeen || hiCnt > FILTER_CYC + LAG;
    uvSeen <= uvSeen || loCnt > FILTER_CYC + LAG;
    if (!rst_n || switchDriveOn)
      ocTrip <= 1'b0;
    else if (ocCnt >= CB_TOP / CB_UP)
      ocTrip <= 1'b1;
  end
  sequence lockHeld;
    supplyLockout [*8];
  endsequence
  sequence hostOff;
    regWrEn && regAddr == 8'h00 && !regWrData[3] && !supplyLockout;
  endsequence
  lock_off_a: assert property (lockHeld |-> !switchDriveOn)
    else $error("drive on in lockout");
  ov_trip_a: assert property (hiCnt > FILTER_CYC + LAG |-> !switchDriveOn)
    else $error("drive on in overvoltage");
  uv_trip_a: assert property (loCnt > FILTER_CYC + LAG |-> !switchDriveOn)
    else $error("drive on in undervoltage");
  ov_back_a: assert property ($rose(switchDriveOn) && ovSeen |-> hiLow >= QUAL_CYC)
    else $error("early turn-on after overvoltage");
  uv_back_a: assert property ($rose(switchDriveOn) && uvSeen |-> loHigh >= QUAL_CYC)
    else $error("early turn-on after undervoltage");
  breaker_trip_a: assert property (ocCnt <= OC_MAX)
    else $error("limit outlasted breaker delay");
  cool_down_a: assert property ($rose(switchDriveOn) && ocTrip |-> offCnt >= COOL_MIN)
    else $error("retry before cool-down end");
  host_off_a: assert property (hostOff |-> ##[1:2] !switchDriveOn)
    else $error("host turn-off ignored");
endmodule
bind ifs_inrush_fault_supervisor ifs_sup_props #(.CW(CW), .QUAL_CYC(QUAL_CYC),
  .FILTER_CYC(FILTER_CYC), .CB_TOP(CB_TOP), .CB_LOW(CB_LOW), .CB_UP(CB_UP),
  .CB_DOWN(CB_DOWN)) i_props (.ref_clk, .rst_n, .highInputSense, .lowInputSense,
  .currentLimitActive, .supplyLockout, .regAddr, .regWrData, .regWrEn, .switchDriveOn);

// *** tb_top.sv ***
// Self-checking bench for the inrush fault supervisor.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, hiIn = 1'b0, loIn = 1'b1, card = 1'b1, lock = 1'b1;
  logic shortLoad = 1'b0, gateLeak = 1'b0, leakPath = 1'b0, rdPend = 1'b0;
  logic regWrEn = 1'b0, regRdEn = 1'b0, switchDriveOn, climit, dsHigh, gateOk, leakSeen;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [7:0] nvCtl = 8'h27, nvDelay = 8'h05;
  logic [31:0] seed = 32'h12a49c43;
  logic [7:0] rdQ[$];
  int fail_count = 0, checks = 0, cyc = 0;
  // Short counts: filter 6, qualify 50, 1ms step 20, breaker 40 down to 10.
  ifs_inrush_fault_supervisor #(.QUAL_CYC(22'h32), .STEP_CYC(22'h14), .FILTER_CYC(22'h6),
    .CB_TOP(12'h28), .CB_LOW(12'h0a)) i_dut (.ref_clk, .rst_n, .highInputSense(hiIn),
    .lowInputSense(loIn), .cardSense(card), .currentLimitActive(climit),
    .drainSourceHigh(dsHigh), .gateEnhanced(gateOk), .leakMeasured(leakSeen),
    .supplyLockout(lock), .nvControl(nvCtl), .nvHealthDelay(nvDelay), .regAddr, .regWrData,
    .regWrEn, .regRdEn, .regRdData, .switchDriveOn);
  ifs_pass_switch_model i_fet (.ref_clk, .switchDriveOn, .shortLoad, .gateLeak, .leakPath,
    .currentLimitActive(climit), .drainSourceHigh(dsHigh), .gateEnhanced(gateOk),
    .leakMeasured(leakSeen));
  initial
    forever #12.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge ref_clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    regAddr = a;
    regRdEn = 1'b1;
    rdQ.push_back(e);
    @(negedge ref_clk);
    regRdEn = 1'b0;
  endtask
  task automatic sw(input logic e);
    cmp("switch", {7'h00, e}, {7'h00, switchDriveOn});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk)
    rdPend <= regRdEn;
  always @(negedge ref_clk)
    if (rdPend && rdQ.size() > 0)
      cmp("read", rdQ.pop_front(), regRdData);
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    wt(8);
    rst_n = 1'b1;
    wt(10);
    lock = 1'b0;
    wt(20);
    rd(8'h00, 8'h27);
    wt(80);
    sw(1'b0);
    $display("test lockout done");
    wr(8'h00, 8'h2f);
    wt(80);
    sw(1'b1);
    seed = lfsr_next(seed);
    wr(8'h06, seed[7:0]);
    rd(8'h06, seed[7:0]);
    wr(8'h1e, seed[15:8]);
    rd(8'h1e, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h06, 8'h05);
    hiIn = 1'b1;
    wt(20);
    sw(1'b0);
    rd(8'h1e, 8'h01);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h01);
    hiIn = 1'b0;
    wt(30);
    sw(1'b0);
    wt(40);
    sw(1'b1);
    rd(8'h04, 8'h01);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h00);
    $display("test overvoltage done");
    wr(8'h00, 8'h2d);
    loIn = 1'b0;
    wt(20);
    sw(1'b0);
    rd(8'h04, 8'h02);
    loIn = 1'b1;
    wt(70);
    sw(1'b0);
    wr(8'h04, 8'h00);
    wt(5);
    sw(1'b1);
    wr(8'h00, 8'h2f);
    $display("test undervoltage done");
    shortLoad = 1'b1;
    wt(5);
    shortLoad = 1'b0;
    wt(40);
    sw(1'b1);
    rd(8'h04, 8'h00);
    shortLoad = 1'b1;
    wt(30);
    sw(1'b0);
    shortLoad = 1'b0;
    rd(8'h04, 8'h04);
    wt(7000);
    rd(8'h1e, 8'h04);
    wt(3500);
    sw(1'b1);
    wr(8'h04, 8'h00);
    $display("test overcurrent done");
    wr(8'h00, 8'h2b);
    gateLeak = 1'b1;
    wt(130);
    sw(1'b0);
    gateLeak = 1'b0;
    rd(8'h04, 8'h40);
    wt(10500);
    sw(1'b0);
    wr(8'h04, 8'h00);
    wt(5);
    sw(1'b1);
    wr(8'h06, 8'h00);
    gateLeak = 1'b1;
    wt(200);
    sw(1'b1);
    gateLeak = 1'b0;
    $display("test health done");
    wr(8'h00, 8'h27);
    leakPath = 1'b1;
    wt(20);
    rd(8'h1e, 8'h20);
    rd(8'h04, 8'h20);
    leakPath = 1'b0;
    wt(10);
    card = 1'b0;
    wt(10);
    rd(8'h04, 8'h10);
    card = 1'b1;
    wt(10);
    rd(8'h00, 8'h2f);
    sw(1'b1);
    wr(8'h00, 8'h0f);
    wt(10);
    sw(1'b0);
    card = 1'b0;
    wt(10);
    sw(1'b1);
    card = 1'b1;
    wt(60);
    wr(8'h00, 8'h4f);
    card = 1'b0;
    wt(20);
    sw(1'b0);
    wt(60);
    sw(1'b1);
    wt(2);
    $display("test card sense done");
    wr(8'h00, 8'h8f);
    card = 1'b1;
    wt(10);
    sw(1'b0);
    leakPath = 1'b1;
    wt(10);
    leakPath = 1'b0;
    wt(10);
    card = 1'b0;
    wt(10);
    rd(8'h04, 8'h30);
    rd(8'h00, 8'h8f);
    sw(1'b1);
    $display("test retained log done");
    nvCtl = 8'h0f;
    nvDelay = seed[23:16];
    lock = 1'b1;
    wt(10);
    sw(1'b0);
    rd(8'h04, 8'h00);
    lock = 1'b0;
    wt(40);
    rd(8'h00, 8'h0f);
    rd(8'h06, seed[23:16]);
    sw(1'b1);
    $display("test lockout reload done");
    tally_and_finish();
  end
endmodule
